// [gtw_map.svh]
// gtw_map.svh: offsets, reset values and timing counts of the guard timer
// assumes: included by bare name; the system clock runs at 250 MHz
`ifndef GTW_MAP_SVH
`define GTW_MAP_SVH

// reload value and counter after reset (0400h, about 102.4 ms nominal)
`define GTW_RELOAD_RESET 16'h0400
`define GTW_COUNT_RESET 16'h0400
`define GTW_COUNT_ONE 16'h0001

// unlock keys written to the high reload address
`define GTW_UNLOCK_KEY1 8'h55
`define GTW_UNLOCK_KEY2 8'haa

// byte fields of the 16-bit reload and count values
`define GTW_HIGH_MSB 15
`define GTW_HIGH_LSB 8
`define GTW_LOW_MSB 7
`define GTW_LOW_LSB 0

// system clock period and short reset pulse length
`define GTW_CLK_PERIOD_PS 4000
`define GTW_RESET_PULSE_NS 32
`define GTW_RESET_PULSE_CYC \
  ((`GTW_RESET_PULSE_NS * 1000 + `GTW_CLK_PERIOD_PS - 1) / `GTW_CLK_PERIOD_PS)
`define GTW_RESET_CNT_W 4

`endif

// [gtw_pkg.sv]
// gtw_pkg.sv: types shared by the guard timer modules
// assumes: gtw_map.svh is on the include path
package gtw_pkg;

  // unlock sequence of the reload registers
  typedef enum logic [1:0] {
    UNL_LOCKED,
    UNL_KEY1,
    UNL_HIGH,
    UNL_LOW
  } gtw_unlock_t;

  // whole state of the guard timer top
  typedef struct packed {
    gtw_unlock_t unl;
    logic on;
    logic [15:0] cnt;
    logic [15:0] rld;
    logic lvl;
    logic exc;
    logic rst;
    logic [3:0] rstcnt;
    logic smr;
    logic st_guard;
    logic st_stop;
    logic [7:0] rd;
  } gtw_state_t;

endpackage : gtw_pkg

// [gtw_sync.sv]
// gtw_sync.sv: three-stage synchroniser for inputs from outside clk_sys
// assumes: only stages two and three are looked at by the user
`timescale 1ns/1ps
module gtw_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] stage2,
  output logic [WIDTH-1:0] stage3
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
  } gtw_sync_state_t;

  gtw_sync_state_t st_q;
  gtw_sync_state_t st_d;

  // shift the input through three flops
  always_comb
  begin
    st_d = st_q;
    st_d.s1 = async_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
  end

  // register stages, cleared on reset
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign stage2 = st_q.s2;
  assign stage3 = st_q.s3;

endmodule : gtw_sync

// [gtw_top.sv]
// gtw_top.sv: guard timer, a 16-bit reloadable down counter with expiry response
// assumes: cpu strobes are on clk_sys; rc oscillator arrives as a pin level
`timescale 1ns/1ps
`include "gtw_map.svh"
module gtw_top (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic osc_clk_pin,
  input wire logic guard_osc_enable,
  input wire logic always_on_option,
  input wire logic timeout_response_option,
  input wire logic stop_mode,
  input wire logic debug_mode,
  input wire logic refresh_instr,
  input wire logic reg_wr,
  input wire logic reg_wr_high,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd_high,
  input wire logic status_clear,
  output logic [7:0] read_data,
  output logic exception_req,
  output logic reset_req,
  output logic stop_recovery_req,
  output logic status_guard,
  output logic status_stop,
  output logic timer_on
);

  gtw_pkg::gtw_state_t st_q;
  gtw_pkg::gtw_state_t st_d;
  logic osc_s2;
  logic osc_s3;
  logic tick;
  logic expire;
  logic key2_hit;

  // oscillator level into the clk_sys domain
  gtw_sync #(
    .WIDTH(1)
  ) u_osc_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .async_in(osc_clk_pin),
    .stage2(osc_s2),
    .stage3(osc_s3)
  );

  // one tick per rising oscillator edge, only with the oscillator enabled
  assign tick = osc_s2 & osc_s3 & ~st_q.lvl & guard_osc_enable;

  // terminal count reached on this tick, unless a refresh or debug mode wins
  assign expire = st_q.on & tick & ~refresh_instr & ~debug_mode
    & (st_q.cnt <= `GTW_COUNT_ONE);

  // second unlock key accepted
  assign key2_hit = reg_wr & reg_wr_high & (reg_wdata == `GTW_UNLOCK_KEY2)
    & (st_q.unl == gtw_pkg::UNL_KEY1);

  // next state of the whole timer
  always_comb
  begin
    st_d = st_q;
    st_d.exc = 1'b0;
    st_d.smr = 1'b0;
    // filtered oscillator level changes once stages agree
    if (osc_s2 == osc_s3)
    begin
      st_d.lvl = osc_s3;
    end
    // count bytes on the reload addresses
    st_d.rd = reg_rd_high ? st_q.cnt[`GTW_HIGH_MSB:`GTW_HIGH_LSB]
      : st_q.cnt[`GTW_LOW_MSB:`GTW_LOW_LSB];
    // unlock sequence; key writes leave the reload bytes alone
    if (reg_wr)
    begin
      unique case (st_q.unl)
        gtw_pkg::UNL_LOCKED:
        begin
          st_d.unl = (reg_wr_high && reg_wdata == `GTW_UNLOCK_KEY1)
            ? gtw_pkg::UNL_KEY1 : gtw_pkg::UNL_LOCKED;
        end
        gtw_pkg::UNL_KEY1:
        begin
          st_d.unl = key2_hit ? gtw_pkg::UNL_HIGH : gtw_pkg::UNL_LOCKED;
        end
        gtw_pkg::UNL_HIGH:
        begin
          if (reg_wr_high)
          begin
            st_d.rld[`GTW_HIGH_MSB:`GTW_HIGH_LSB] = reg_wdata;
            st_d.unl = gtw_pkg::UNL_LOW;
          end
          else
          begin
            st_d.unl = gtw_pkg::UNL_LOCKED;
          end
        end
        gtw_pkg::UNL_LOW:
        begin
          if (!reg_wr_high)
          begin
            st_d.rld[`GTW_LOW_MSB:`GTW_LOW_LSB] = reg_wdata;
          end
          st_d.unl = gtw_pkg::UNL_LOCKED;
        end
      endcase
    end
    // short reset pulse countdown
    if (st_q.rstcnt != '0)
    begin
      st_d.rstcnt = st_q.rstcnt - 4'h1;
    end
    // software clear of sticky status; a set below wins
    if (status_clear)
    begin
      st_d.st_guard = 1'b0;
      st_d.st_stop = 1'b0;
    end
    // turn on, refresh, count and expire
    if (!st_q.on)
    begin
      if (refresh_instr || always_on_option)
      begin
        st_d.on = 1'b1;
        st_d.cnt = st_q.rld;
      end
    end
    else if (refresh_instr || debug_mode)
    begin
      st_d.cnt = st_q.rld;
    end
    else if (expire)
    begin
      st_d.st_guard = 1'b1;
      if (stop_mode)
      begin
        st_d.smr = 1'b1;
        st_d.st_stop = 1'b1;
      end
      if (!timeout_response_option)
      begin
        st_d.exc = 1'b1;
        st_d.cnt = st_q.rld;
      end
      else if (stop_mode)
      begin
        st_d.cnt = st_q.rld;
      end
      else
      begin
        // device goes to reset: on, cnt, rld and unl return to their reset values; status_guard stays set
        st_d.rstcnt = 4'(`GTW_RESET_PULSE_CYC);
        st_d.on = 1'b0;
        st_d.cnt = `GTW_COUNT_RESET;
        st_d.rld = `GTW_RELOAD_RESET;
        st_d.unl = gtw_pkg::UNL_LOCKED;
      end
    end
    else if (tick)
    begin
      st_d.cnt = st_q.cnt - 16'h0001;
    end
    st_d.rst = (st_d.rstcnt != '0);
  end

  // state register with reset values
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_q <= '0;
      st_q.unl <= gtw_pkg::UNL_LOCKED;
      st_q.cnt <= `GTW_COUNT_RESET;
      st_q.rld <= `GTW_RELOAD_RESET;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // outputs straight from flops
  assign read_data = st_q.rd;
  assign exception_req = st_q.exc;
  assign reset_req = st_q.rst;
  assign stop_recovery_req = st_q.smr;
  assign status_guard = st_q.st_guard;
  assign status_stop = st_q.st_stop;
  assign timer_on = st_q.on;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  property p_unlock_key2;
    key2_hit |=> st_q.unl == gtw_pkg::UNL_HIGH ##1 1'b1;
  endproperty
  a_unlock_key2: assert property (p_unlock_key2)
    else $error("second key did not unlock the high byte");

  property p_read_count;
    reg_rd_high ##1 !reg_rd_high |-> read_data == $past(st_q.cnt[15:8]);
  endproperty
  a_read_count: assert property (p_read_count)
    else $error("high read did not return the count");

  property p_refresh_reload;
    refresh_instr && st_q.on |=> st_q.cnt == $past(st_q.rld);
  endproperty
  a_refresh_reload: assert property (p_refresh_reload)
    else $error("refresh did not reload the counter");

  property p_debug_no_expiry;
    debug_mode && st_q.on |=> !exception_req && !stop_recovery_req && !$rose(reset_req);
  endproperty
  a_debug_no_expiry: assert property (p_debug_no_expiry)
    else $error("expiry response while in debug mode");

  property p_exc_reload;
    expire && !timeout_response_option
      |=> exception_req && st_q.on && st_q.cnt == $past(st_q.rld);
  endproperty
  a_exc_reload: assert property (p_exc_reload)
    else $error("exception expiry did not request and reload");

  property p_reset_pulse;
    expire && timeout_response_option && !stop_mode
      |=> status_guard ##0 reset_req[*8] ##1 !reset_req;
  endproperty
  a_reset_pulse: assert property (p_reset_pulse)
    else $error("reset response pulse length or status wrong");

  property p_stop_recovery;
    expire && stop_mode
      |=> stop_recovery_req && status_guard && status_stop && !reset_req;
  endproperty
  a_stop_recovery: assert property (p_stop_recovery)
    else $error("stop expiry did not recover and set status");

  property p_osc_off_hold;
    !guard_osc_enable && st_q.on && !refresh_instr && !debug_mode
      |=> $stable(st_q.cnt) && !exception_req;
  endproperty
  a_osc_off_hold: assert property (p_osc_off_hold)
    else $error("counter moved with the oscillator disabled");

  property p_first_on;
    !st_q.on && always_on_option && !reset_req
      |=> st_q.on && st_q.cnt == $past(st_q.rld);
  endproperty
  a_first_on: assert property (p_first_on)
    else $error("first turn-on did not load the reload value");

  property p_unlock_refuse;
    reg_wr && st_q.unl == gtw_pkg::UNL_KEY1 && !key2_hit
      |=> st_q.unl == gtw_pkg::UNL_LOCKED;
  endproperty
  a_unlock_refuse: assert property (p_unlock_refuse)
    else $error("out of order write did not relock");

  property p_reload_low;
    reg_wr && !reg_wr_high && st_q.unl == gtw_pkg::UNL_LOW && !expire
      |=> st_q.rld[`GTW_LOW_MSB:`GTW_LOW_LSB] == $past(reg_wdata);
  endproperty
  a_reload_low: assert property (p_reload_low)
    else $error("low reload byte not taken after unlock");

  property p_tick_count;
    tick && st_q.on && !refresh_instr && !debug_mode && !expire
      |=> st_q.cnt == $past(st_q.cnt) - 16'h0001;
  endproperty
  a_tick_count: assert property (p_tick_count)
    else $error("counter did not step down on an oscillator tick");

  property p_reset_restart;
    expire && timeout_response_option && !stop_mode
      |=> !timer_on && st_q.cnt == `GTW_COUNT_RESET && st_q.rld == `GTW_RELOAD_RESET;
  endproperty
  a_reset_restart: assert property (p_reset_restart)
    else $error("reset response did not restore counter reset values");

  property p_stop_reset;
    expire && timeout_response_option && stop_mode
      |=> stop_recovery_req && !exception_req && st_q.cnt == $past(st_q.rld);
  endproperty
  a_stop_reset: assert property (p_stop_reset)
    else $error("reset-mode expiry in stop did not recover and reload");

endmodule : gtw_top

// [gtw_osc_model.sv]
// rc oscillator and exception counter on the far side of the guard timer
// assumes: clk_sys at 250 MHz; oscillator period is 16 clk when running
`timescale 1ns/1ps
module gtw_osc_model (
  input wire logic clk_sys,
  input wire logic run,
  input wire logic exception_req,
  output logic osc_clk_pin,
  output int exc_cnt
);
  int ph = 0;
  initial osc_clk_pin = 1'b0;
  initial exc_cnt = 0;
  // oscillator stands still while disabled
  always @(posedge clk_sys)
  begin
    if (run)
    begin
      ph = (ph + 1) % 8;
      if (ph == 0)
        osc_clk_pin <= ~osc_clk_pin;
    end
    if (exception_req === 1'b1)
      exc_cnt <= exc_cnt + 1;
  end
endmodule : gtw_osc_model

// [guard_timer_watchdog_tb_top.sv]
// self-checking bench of the guard timer
// assumes: gtw_top and gtw_osc_model compiled before it
`timescale 1ns/1ps
module guard_timer_watchdog_tb_top;
  logic clk_sys = 0, reset_n = 0, osc_clk_pin, en = 0, ao = 0, rsp = 0;
  logic stp = 0, dbg = 0, rfr = 0, wr = 0, wrh = 0, rdh = 0, clr = 0;
  logic [7:0] wd = 8'h00, read_data;
  logic exception_req, reset_req, stop_recovery_req, status_guard, status_stop, timer_on;
  logic [15:0] v, rl;
  int n_errors = 0, checks_done = 0, seed = 32'h7bf1, exc_cnt, t0, k;
  always #2 clk_sys = ~clk_sys;
  gtw_osc_model i_osc (.clk_sys(clk_sys), .run(en), .exception_req(exception_req),
    .osc_clk_pin(osc_clk_pin), .exc_cnt(exc_cnt));
  gtw_top i_dut (.clk_sys(clk_sys), .reset_n(reset_n), .osc_clk_pin(osc_clk_pin),
    .guard_osc_enable(en), .always_on_option(ao), .timeout_response_option(rsp),
    .stop_mode(stp), .debug_mode(dbg), .refresh_instr(rfr), .reg_wr(wr),
    .reg_wr_high(wrh), .reg_wdata(wd), .reg_rd_high(rdh), .status_clear(clr),
    .read_data(read_data), .exception_req(exception_req), .reset_req(reset_req),
    .stop_recovery_req(stop_recovery_req), .status_guard(status_guard),
    .status_stop(status_stop), .timer_on(timer_on));
  // closing report
  task conclude;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : conclude
  task step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : step
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // expected expiry interval in clk cycles: one count per 16-clk osc period
  function int exp_cycles(input logic [15:0] r);
    return r * 16;
  endfunction : exp_cycles
  // strobe stays up between back-to-back writes; the caller lowers it
  task wrb(input logic hi, input logic [7:0] d);
    wr = 1;
    wrh = hi;
    wd = d;
    step(1);
  endtask : wrb
  // read both count bytes, one cycle of latency each
  task rd16;
    rdh = 1;
    step(2);
    v[15:8] = read_data;
    rdh = 0;
    step(2);
    v[7:0] = read_data;
  endtask : rd16
  task pulse_refresh;
    rfr = 1;
    step(1);
    rfr = 0;
  endtask : pulse_refresh
  // bounded wait for exception (0), reset (1) or stop recovery (2) request
  task wait_hi(input int sel, input int bound);
    k = 0;
    while ((sel == 2 ? stop_recovery_req : sel == 1 ? reset_req : exception_req) !== 1'b1)
    begin
      step(1);
      if (++k > bound)
      begin
        n_errors++;
        $display("wrong value at %0t: got %h expected %h", $time, 0, 1);
        conclude();
      end
    end
  endtask : wait_hi
  initial
  begin
    step(4);
    reset_n = 1;
    step(1);
    rd16(); chk(v, 16'h0400);
    chk(timer_on, 0);
    rl = 16'h0004 + ($random(seed) & 16'h001f);
    wrb(1, 8'h55); wrb(1, 8'haa); wrb(1, rl[15:8]); wrb(0, rl[7:0]);
    wrb(1, 8'h55); wrb(0, 8'hff); wrb(1, 8'haa); wrb(1, 8'h00); wrb(0, 8'h01);
    wr = 0;
    pulse_refresh();
    chk(timer_on, 1);
    rd16(); chk(v, rl);
    step(100);
    rd16(); chk(v, rl);
    en = 1;
    wait_hi(0, exp_cycles(rl) + 100);
    chk(status_guard, 1);
    t0 = $time;
    step(1);
    wait_hi(0, exp_cycles(rl) + 100);
    k = ($time - t0) / 4;
    chk(k >= exp_cycles(rl) - 4 && k <= exp_cycles(rl) + 4, 1);
    clr = 1; step(1); clr = 0;
    chk(status_guard, 0);
    dbg = 1;
    t0 = exc_cnt;
    step(rl * 48 + 20);
    chk(exc_cnt - t0, 0);
    dbg = 0;
    step(rl * 8);
    pulse_refresh();
    step(rl * 10);
    chk(exc_cnt - t0, 0);
    stp = 1;
    wait_hi(0, exp_cycles(rl) + 100);
    chk(stop_recovery_req, 1);
    step(1);
    chk({status_guard, status_stop}, 3);
    clr = 1; step(1); clr = 0;
    rsp = 1;
    wait_hi(2, exp_cycles(rl) + 100);
    chk({exception_req, reset_req, stop_recovery_req, status_guard, status_stop}, 5'h07);
    stp = 0;
    wait_hi(1, exp_cycles(rl) + 100);
    for (k = 0; k < 20 && reset_req === 1'b1; k++)
      step(1);
    chk(k, 8);
    chk({status_guard, timer_on}, 2);
    en = 0;
    rd16(); chk(v, 16'h0400);
    ao = 1;
    step(2);
    chk(timer_on, 1);
    conclude();
  end
endmodule : guard_timer_watchdog_tb_top
